//--- bench/ppr_top_asserts.sv
/* Checker for ppr_top: bus answer, read-back and routing relations.
   Assumes it is bound to ppr_top, one clock. */
`timescale 1ns/1ns
module ppr_top_asserts (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic cpuIdle,
    input wire logic [15:0] pinIn,
    input wire logic [15:0] periphOut,
    input wire logic [7:0] periphIn,
    input wire logic [7:0] pinOut,
    input wire logic [6:0] changeNoticeActive
);
    logic lockSeen; // Shadow of the lock bit
    logic rdAck; // Read answer cycle
    logic [3:0] grp; // Register group
    logic [2:0] idx; // Index in group
    logic cnOk; // Mapped port control
    assign rdAck = wb_ack_o && !wb_we_i;
    assign grp = wb_adr_i[11:8];
    assign idx = wb_adr_i[4:2];
    assign cnOk = grp == 4'h3 && wb_adr_i[7:2] < 6'h7;
    // Follow lock writes
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            lockSeen <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i[11:2] == 10'h0 && wb_sel_i[1]) begin
            lockSeen <= wb_dat_i[13];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack timing wrong");
    a_sel_upper_zero: assert property (
        rdAck && (grp == 4'h1 || grp == 4'h2) |-> wb_dat_o[31:4] == 28'h0) else $error("sel high bits");
    a_cn_reserved: assert property (
        rdAck && grp == 4'h3 |-> (wb_dat_o & 32'hffff5fff) == 32'h0) else $error("cn spare bits");
    a_cn_off: assert property (
        rdAck && cnOk && !wb_dat_o[15] |-> !changeNoticeActive[idx]) else $error("cn not off");
    a_cn_idle_stop: assert property (
        rdAck && cnOk && wb_dat_o[15] |-> changeNoticeActive[idx] == !(wb_dat_o[13] && cpuIdle))
        else $error("cn idle wrong");
    a_route_input: assert property (
        rdAck && grp == 4'h1 && wb_adr_i[7:5] == 3'h0 |-> periphIn[idx] == pinIn[wb_dat_o[3:0]])
        else $error("input route");
    a_route_output: assert property (
        rdAck && grp == 4'h2 && wb_adr_i[7:5] == 3'h0 |-> pinOut[idx] == periphOut[wb_dat_o[3:0]])
        else $error("output route");
    a_lock_holds: assert property (
        wb_ack_o && wb_we_i && lockSeen && (grp == 4'h1 || grp == 4'h2) && $stable(pinIn)
        && $stable(periphOut) |-> $stable(periphIn) && $stable(pinOut)) else $error("lock ignored");
    c_idle_read: cover property (rdAck && cnOk && cpuIdle);
    c_locked_write: cover property (wb_ack_o && wb_we_i && lockSeen);
    c_pin_read: cover property (rdAck && grp == 4'h2);
endmodule : ppr_top_asserts

bind ppr_top ppr_top_asserts u_ppr_top_asserts (.*);

//--- bench/ppr_top_tb.sv
/* Bench for ppr_top: Wishbone register accesses and routing checks.
   Assumes package, design and checker compiled first. */
`timescale 1ns/1ns
module ppr_top_tb;
    import ppr_pkg::*;
    logic ref_clk, resetn, we, cyc, stb, ack, cpuIdle;
    logic [ADDR_WIDTH-1:0] adr;
    logic [31:0] wdat, rdat, rd;
    logic [15:0] pinIn, periphOut;
    logic [7:0] periphIn, pinOut, expOut;
    logic [6:0] cn;
    logic [3:0] sel; // Byte lanes of the current request
    int mismatches, checked, cycles;
    ppr_top u_ppr_top (.ref_clk(ref_clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_ack_o(ack), .cpuIdle(cpuIdle), .pinIn(pinIn), .periphOut(periphOut),
        .periphIn(periphIn), .pinOut(pinOut), .changeNoticeActive(cn));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // Hang guard
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles > 3000) begin
            mismatches++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One classic cycle, held until ack
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : xfer
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    task automatic summarize;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    initial begin
        {cyc, stb, we, cpuIdle, resetn} = 5'h0;
        {adr, wdat, mismatches, checked, cycles} = '0;
        sel = 4'hf;
        pinIn = 16'h8000;
        periphOut = 16'h5a3c;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        rdchk(12'h104, 32'h0);
        rdchk(12'h21c, 32'h0);
        rdchk(12'h318, 32'h0);
        xfer(1'b1, 12'h108, 32'hffffffff);
        rdchk(12'h108, 32'hf);
        check(32'(periphIn[2]), 32'h1);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 12'h200 + 12'(4 * i), 32'(15 - i));
            expOut[i] = periphOut[15 - i];
        end
        check(32'(pinOut), 32'(expOut));
        rdchk(12'h20c, 32'hc);
        xfer(1'b1, 12'h30c, 32'hffffffff);
        rdchk(12'h30c, 32'h0000a000);
        check(32'(cn[3]), 32'h1);
        cpuIdle <= 1'b1;
        @(posedge ref_clk);
        check(32'(cn[3]), 32'h0);
        xfer(1'b1, 12'h30c, 32'h00008000);
        rdchk(12'h30c, 32'h00008000);
        check(32'(cn[3]), 32'h1);
        xfer(1'b1, 12'h30c, 32'h0);
        check(32'(cn[3]), 32'h0);
        rdchk(12'h1c0, 32'h0);
        xfer(1'b1, 12'h000, 32'h00002000);
        xfer(1'b1, 12'h108, 32'h5);
        rdchk(12'h108, 32'hf);
        xfer(1'b1, 12'h000, 32'h0);
        xfer(1'b1, 12'h108, 32'h5);
        rdchk(12'h108, 32'h5);
        check(32'(periphIn[2]), 32'h0);
        // Select write without the low byte lane must leave the field alone
        sel <= 4'he;
        xfer(1'b1, 12'h108, 32'h3);
        sel <= 4'hf;
        rdchk(12'h108, 32'h5);
        summarize();
    end
endmodule : ppr_top_tb

//--- rtl/ppr_pkg.sv
/*
 * Shared constants and types for the pin remap and change-notice block.
 * Assumes a 32-bit classic Wishbone slave with word addressing by byte address.
 */
package ppr_pkg;

    // Counts of remappable inputs, pins and ports
    localparam int NUM_INPUTS = 8;
    localparam int NUM_PINS = 8;
    localparam int NUM_PORTS = 7;
    localparam int SEL_WIDTH = 4;
    localparam int ADDR_WIDTH = 12;

    // Presence masks for device variants, one bit per select register
    localparam logic [NUM_INPUTS-1:0] INPUT_PRESENT = 8'hff;
    localparam logic [NUM_PINS-1:0] PIN_PRESENT = 8'hff;

    // Register map, byte addresses
    localparam logic [ADDR_WIDTH-1:0] CFG_CTRL_OFFSET = 12'h000;
    localparam logic [ADDR_WIDTH-1:0] INPUT_SEL_BASE = 12'h100;
    localparam logic [ADDR_WIDTH-1:0] PIN_SEL_BASE = 12'h200;
    localparam logic [ADDR_WIDTH-1:0] CN_CTRL_BASE = 12'h300;

    // Field positions
    localparam int LOCK_BIT = 13;
    localparam int CN_ENABLE_BIT = 15;
    localparam int CN_IDLE_STOP_BIT = 13;

    // Reset values
    localparam logic [SEL_WIDTH-1:0] SEL_RESET = 4'h0;
    localparam logic CTRL_BIT_RESET = 1'b0;

    // Bus answer state
    typedef enum logic [0:0] {
        BUS_IDLE = 1'b0,
        BUS_ACK = 1'b1
    } ppr_bus_type;

endpackage : ppr_pkg

//--- rtl/ppr_route_if.sv
/*
 * Carrier for the select fields between the register file and the router.
 * Assumes ppr_pkg is compiled first.
 */
`timescale 1ns/1ns
interface ppr_route_if;
    import ppr_pkg::*;
    logic [SEL_WIDTH-1:0] inputSel [NUM_INPUTS]; // Source choice per input
    logic [SEL_WIDTH-1:0] pinSel [NUM_PINS]; // Function choice per pin
    modport regs (output inputSel, output pinSel);
    modport router (input inputSel, input pinSel);
endinterface : ppr_route_if

//--- rtl/ppr_router.sv
/*
 * Pin routing mux: steers pins to peripheral inputs and outputs to pins.
 * Assumes select fields are registered by the caller.
 */
`timescale 1ns/1ns
module ppr_router (
    ppr_route_if.router sel,
    input wire logic [15:0] pinIn,
    input wire logic [15:0] periphOut,
    output logic [ppr_pkg::NUM_INPUTS-1:0] periphIn,
    output logic [ppr_pkg::NUM_PINS-1:0] pinOut
);
    import ppr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // One mux per input and per pin
    genvar i;
    generate
        for (i = 0; i < NUM_INPUTS; i++) begin : gIn
            assign periphIn[i] = pinIn[sel.inputSel[i]];
        end
        for (i = 0; i < NUM_PINS; i++) begin : gPin
            assign pinOut[i] = periphOut[sel.pinSel[i]];
        end
    endgenerate
endmodule : ppr_router

//--- rtl/ppr_top.sv
/*
 * Pin remap registers, change-notice port control and a Wishbone slave.
 * Assumes a classic Wishbone master on ref_clk and an asynchronous reset.
 */
// Overview of operation
// R1: Input select holds 4-bit field, reset zero
// R2: Select bits 31..4 read zero, ignore writes
// R3: Pin output select holds 4-bit field
// R4: Select writes accepted only while lock clear
// R5: Absent select registers not implemented per variant
// R6: Change-notice enable bit 15, reset zero
// R7: Stop-in-idle bit 13 halts when idle
// R8: Other change-notice bits read zero
// R9: Accepted select change routes next cycle
`timescale 1ns/1ns
module ppr_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ppr_pkg::ADDR_WIDTH-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic cpuIdle,
    input wire logic [15:0] pinIn,
    input wire logic [15:0] periphOut,
    output logic [ppr_pkg::NUM_INPUTS-1:0] periphIn,
    output logic [ppr_pkg::NUM_PINS-1:0] pinOut,
    output logic [ppr_pkg::NUM_PORTS-1:0] changeNoticeActive
);
    import ppr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // State
    ppr_route_if route ();
    ppr_bus_type busState; // Answer state
    ppr_bus_type next_busState;
    logic [31:0] readData; // Registered read data
    logic [31:0] next_readData;
    logic pinConfigLock; // Configuration lock
    logic next_pinConfigLock;
    logic [SEL_WIDTH-1:0] inputSel [NUM_INPUTS];
    logic [SEL_WIDTH-1:0] next_inputSel [NUM_INPUTS];
    logic [SEL_WIDTH-1:0] pinSel [NUM_PINS];
    logic [SEL_WIDTH-1:0] next_pinSel [NUM_PINS];
    logic [NUM_PORTS-1:0] cnEnable; // Per-port change-notice enable
    logic [NUM_PORTS-1:0] next_cnEnable;
    logic [NUM_PORTS-1:0] cnIdleStop; // Per-port stop in idle
    logic [NUM_PORTS-1:0] next_cnIdleStop;

    // Request decode
    logic request;
    logic writeHit;
    logic [3:0] regIndex;
    logic [3:0] regGroup;
    assign request = wb_cyc_i && wb_stb_i && (busState == BUS_IDLE);
    assign writeHit = request && wb_we_i;
    assign regIndex = wb_adr_i[5:2];
    assign regGroup = wb_adr_i[11:8];

    ////////////////////////////////////////////////////////////////////////
    // Next values of all registers and the bus answer
    always_comb begin
        next_busState = BUS_IDLE;
        next_readData = 32'h0000_0000;
        next_pinConfigLock = pinConfigLock;
        next_inputSel = inputSel;
        next_pinSel = pinSel;
        next_cnEnable = cnEnable;
        next_cnIdleStop = cnIdleStop;
        if (request) begin
            // Answer every request, mapped or not, one cycle later
            next_busState = BUS_ACK;
            if (wb_adr_i[7:6] == 2'b00) begin
                case (regGroup)
                    CFG_CTRL_OFFSET[11:8]: begin
                        if (regIndex == 4'h0) begin
                            next_readData[LOCK_BIT] = pinConfigLock;
                            if (wb_we_i && wb_sel_i[LOCK_BIT/8]) begin
                                next_pinConfigLock = wb_dat_i[LOCK_BIT];
                            end
                        end
                    end
                    INPUT_SEL_BASE[11:8]: begin
                        if (regIndex < 4'(NUM_INPUTS) && INPUT_PRESENT[regIndex[2:0]]) begin // [R5]
                            next_readData[SEL_WIDTH-1:0] = inputSel[regIndex[2:0]]; // [R1] [R2]
                            if (writeHit && wb_sel_i[0] && !pinConfigLock) begin // [R4]
                                next_inputSel[regIndex[2:0]] = wb_dat_i[SEL_WIDTH-1:0]; // [R1]
                            end
                        end
                    end
                    PIN_SEL_BASE[11:8]: begin
                        if (regIndex < 4'(NUM_PINS) && PIN_PRESENT[regIndex[2:0]]) begin // [R5]
                            next_readData[SEL_WIDTH-1:0] = pinSel[regIndex[2:0]]; // [R3] [R2]
                            if (writeHit && wb_sel_i[0] && !pinConfigLock) begin // [R4]
                                next_pinSel[regIndex[2:0]] = wb_dat_i[SEL_WIDTH-1:0]; // [R3]
                            end
                        end
                    end
                    CN_CTRL_BASE[11:8]: begin
                        if (regIndex < 4'(NUM_PORTS)) begin
                            // Only bits 15 and 13 exist [R8]
                            next_readData[CN_ENABLE_BIT] = cnEnable[regIndex[2:0]];
                            next_readData[CN_IDLE_STOP_BIT] = cnIdleStop[regIndex[2:0]];
                            if (writeHit && wb_sel_i[1]) begin
                                next_cnEnable[regIndex[2:0]] = wb_dat_i[CN_ENABLE_BIT]; // [R6]
                                next_cnIdleStop[regIndex[2:0]] = wb_dat_i[CN_IDLE_STOP_BIT]; // [R7]
                            end
                        end
                    end
                    default: begin
                        // Unmapped: acknowledged, reads zero, writes dropped
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register all state
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            busState <= BUS_IDLE;
            readData <= 32'h0000_0000;
            pinConfigLock <= CTRL_BIT_RESET;
            for (int k = 0; k < NUM_INPUTS; k++) begin
                inputSel[k] <= SEL_RESET; // [R1]
            end
            for (int k = 0; k < NUM_PINS; k++) begin
                pinSel[k] <= SEL_RESET; // [R3]
            end
            cnEnable <= '0; // [R6]
            cnIdleStop <= '0;
        end else begin
            busState <= next_busState;
            readData <= next_readData;
            pinConfigLock <= next_pinConfigLock;
            inputSel <= next_inputSel;
            pinSel <= next_pinSel;
            cnEnable <= next_cnEnable;
            cnIdleStop <= next_cnIdleStop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign wb_ack_o = (busState == BUS_ACK);
    assign wb_dat_o = readData;

    // Change notice runs when enabled and not halted by idle
    assign changeNoticeActive = cnEnable & ~(cnIdleStop & {NUM_PORTS{cpuIdle}}); // [R6] [R7]

    // Registered selects drive routing the cycle after the write
    always_comb begin
        route.inputSel = inputSel; // [R9]
        route.pinSel = pinSel; // [R9]
    end

    ppr_router uRouter (
        .sel(route.router),
        .pinIn(pinIn),
        .periphOut(periphOut),
        .periphIn(periphIn),
        .pinOut(pinOut)
    );

endmodule : ppr_top
